// ### psc_control.sv
`timescale 1ns/10ps
`default_nettype none
module psc_control
    import psc_pkg::*;
#(
    parameter int CTR_WIDTH = 48,
    parameter logic TRAP_LIKE = 1'b1,
    parameter logic [3:0] RECORD_FMT = 4'h0
)
(
    input wire logic sys_clk_in,
    input wire logic rst_n_in,
    input wire logic msr_wr_in,
    input wire logic msr_rd_in,
    input wire logic [11:0] msr_addr_in,
    input wire logic [63:0] msr_wdata_in,
    input wire logic event_in,
    input wire logic insn_complete_in,
    input wire logic [63:0] core_word_in,
    input wire logic freeze_on_overflow_irq_in,
    input wire logic branch_trace_req_in,
    input wire logic branch_trace_done_in,
    input wire logic mem_ready_in,
    output logic [63:0] msr_rdata_out,
    output logic msr_rd_valid_out,
    output logic msr_err_out,
    output logic mem_valid_out,
    output logic [63:0] mem_addr_out,
    output logic [63:0] mem_data_out,
    output logic [7:0] core_word_sel_out,
    output logic insn_hold_out,
    output logic branch_trace_go_out,
    output logic counter_overflow_interrupt_out,
    output logic sample_done_out
);
    typedef enum logic [2:0] {
        PSC_ST_IDLE = 3'b000,
        PSC_ST_ARMED = 3'b001,
        PSC_ST_WAIT_DONE = 3'b010,
        PSC_ST_CHECK = 3'b011,
        PSC_ST_WRITE = 3'b100
    } psc_state_t;

    psc_state_t state_reg;
    psc_state_t state_next;
    logic [63:0] glb_en_reg;
    logic [63:0] sample_en_reg;
    logic [63:0] evtsel_reg;
    logic [CTR_WIDTH-1:0] ctr_reg;
    logic [63:0] buf_index_reg;
    logic [63:0] buf_max_reg;
    logic [63:0] buf_thresh_reg;
    logic [63:0] reload_reg;
    logic [2:0] content_sel_reg;
    logic ovf0_reg;
    logic buf_full_reg;
    logic irq_pend_reg;
    logic bts_pend_reg;
    logic bts_busy_reg;
    logic insn_hold_reg;
    logic bts_go_reg;
    logic irq_reg;
    logic [63:0] rdata_reg;
    logic rd_valid_reg;
    logic err_reg;

    wire fits;
    wire reach_thresh;
    wire [63:0] next_index;
    wire writer_done;
    wire [7:0] rec_words = psc_record_words(RECORD_FMT, content_sel_reg);

    // register decode
    wire hit_status = msr_addr_in == PSC_ADDR_GLB_STATUS;
    wire hit_glb_en = msr_addr_in == PSC_ADDR_GLB_ENABLE;
    wire hit_ovf_clr = msr_addr_in == PSC_ADDR_OVF_CLEAR;
    wire hit_samp_en = msr_addr_in == PSC_ADDR_SAMPLE_EN;
    wire hit_caps = msr_addr_in == PSC_ADDR_CAPS;
    wire hit_misc = msr_addr_in == PSC_ADDR_MISC;
    wire hit_evtsel = msr_addr_in == PSC_ADDR_EVTSEL;
    wire hit_ctr = msr_addr_in == PSC_ADDR_COUNTER;
    wire hit_index = msr_addr_in == PSC_ADDR_BUF_INDEX;
    wire hit_max = msr_addr_in == PSC_ADDR_BUF_MAX;
    wire hit_thresh = msr_addr_in == PSC_ADDR_BUF_THRESH;
    wire hit_reload = msr_addr_in == PSC_ADDR_RELOAD;
    wire hit_content = msr_addr_in == PSC_ADDR_CONTENT_SEL;
    wire hit_any = hit_status | hit_glb_en | hit_ovf_clr | hit_samp_en | hit_caps | hit_misc
        | hit_evtsel | hit_ctr | hit_index | hit_max | hit_thresh | hit_reload | hit_content;
    wire rd_only = hit_status | hit_caps | hit_misc;
    wire wr_ok = msr_wr_in && hit_any && !rd_only;
    wire rd_ok = msr_rd_in && hit_any && !hit_ovf_clr;

    // status, capability and feature words
    wire [63:0] status_word = ({63'h0, ovf0_reg} << PSC_STS_OVF0_BIT)
        | ({63'h0, buf_full_reg} << PSC_STS_BUF_FULL_BIT);
    wire [63:0] caps_word = ({60'h0, RECORD_FMT} << PSC_CAP_FMT_LSB)
        | (64'h1 << PSC_CAP_SAVE_ALL_BIT)
        | ({63'h0, TRAP_LIKE} << PSC_CAP_TRAP_BIT);
    wire [63:0] misc_word = 64'h1 << PSC_MISC_MON_BIT; // sampling-absent bit reads zero
    wire [63:0] ctr_word = {{(64-CTR_WIDTH){1'b0}}, ctr_reg};

    wire [63:0] rd_word = hit_status ? status_word
        : hit_glb_en ? glb_en_reg
        : hit_samp_en ? sample_en_reg
        : hit_caps ? caps_word
        : hit_misc ? misc_word
        : hit_evtsel ? evtsel_reg
        : hit_ctr ? ctr_word
        : hit_index ? buf_index_reg
        : hit_max ? buf_max_reg
        : hit_thresh ? buf_thresh_reg
        : hit_reload ? reload_reg
        : hit_content ? {61'h0, content_sel_reg}
        : PSC_ZERO64;

    // counting and overflow of counter zero
    wire count_on = glb_en_reg[0] && evtsel_reg[PSC_EVT_ENABLE_BIT];
    wire ctr_at_max = &ctr_reg;
    wire ovf_hit = count_on && event_in && ctr_at_max;
    wire sampling_on = sample_en_reg[PSC_SAMPLE_ON_BIT];

    // sample sequencing
    wire arm_now = ovf_hit && sampling_on;
    wire sample_evt = (state_reg == PSC_ST_ARMED) && sampling_on && count_on && event_in;
    wire check_pass = (state_reg == PSC_ST_CHECK) && fits;
    wire check_fail = (state_reg == PSC_ST_CHECK) && !fits;
    wire stored = (state_reg == PSC_ST_WRITE) && writer_done;
    wire samp_busy = (state_reg == PSC_ST_WAIT_DONE) || (state_reg == PSC_ST_CHECK)
        || (state_reg == PSC_ST_WRITE) || sample_evt;

    // interrupt sources and release
    wire ovf_int_src = ovf_hit && !sampling_on && evtsel_reg[PSC_EVT_INT_BIT];
    wire buf_int_src = (stored && reach_thresh) || check_fail;
    wire irq_fire = irq_pend_reg && !samp_busy && !bts_pend_reg && !bts_busy_reg;
    wire bts_grant = bts_pend_reg && !samp_busy && !bts_busy_reg;

    wire [63:0] ovf_clr_bits = (msr_wr_in && hit_ovf_clr) ? msr_wdata_in : PSC_ZERO64;

    always_comb
    begin
        state_next = state_reg;
        unique case (state_reg)
            PSC_ST_IDLE:
            begin
                if (arm_now)
                begin
                    state_next = PSC_ST_ARMED;
                end
            end
            PSC_ST_ARMED:
            begin
                if (!sampling_on)
                begin
                    state_next = PSC_ST_IDLE;
                end
                else if (sample_evt)
                begin
                    state_next = TRAP_LIKE ? PSC_ST_WAIT_DONE : PSC_ST_CHECK;
                end
            end
            PSC_ST_WAIT_DONE:
            begin
                if (insn_complete_in)
                begin
                    state_next = PSC_ST_CHECK;
                end
            end
            PSC_ST_CHECK:
            begin
                state_next = fits ? PSC_ST_WRITE : PSC_ST_IDLE;
            end
            PSC_ST_WRITE:
            begin
                if (writer_done)
                begin
                    state_next = PSC_ST_IDLE;
                end
            end
            default:
            begin
                state_next = PSC_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk_in)
    begin
        if (!rst_n_in)
        begin
            state_reg <= PSC_ST_IDLE;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    // software-written control
    always_ff @(posedge sys_clk_in)
    begin
        if (!rst_n_in)
        begin
            glb_en_reg <= PSC_ZERO64;
            sample_en_reg <= PSC_ZERO64;
            evtsel_reg <= PSC_ZERO64;
            buf_max_reg <= PSC_ZERO64;
            buf_thresh_reg <= PSC_ZERO64;
            reload_reg <= PSC_ZERO64;
            content_sel_reg <= 3'h0;
        end
        else
        begin
            if (irq_fire && freeze_on_overflow_irq_in)
            begin
                glb_en_reg <= PSC_ZERO64;
            end
            else if (wr_ok && hit_glb_en)
            begin
                glb_en_reg <= msr_wdata_in;
            end
            if (wr_ok && hit_samp_en)
            begin
                sample_en_reg <= msr_wdata_in & 64'h1;
            end
            if (wr_ok && hit_evtsel)
            begin
                evtsel_reg <= msr_wdata_in;
            end
            if (wr_ok && hit_max)
            begin
                buf_max_reg <= msr_wdata_in;
            end
            if (wr_ok && hit_thresh)
            begin
                buf_thresh_reg <= msr_wdata_in;
            end
            if (wr_ok && hit_reload)
            begin
                reload_reg <= msr_wdata_in;
            end
            if (wr_ok && hit_content)
            begin
                content_sel_reg <= msr_wdata_in[2:0];
            end
        end
    end

    // counter, write index and status flags
    always_ff @(posedge sys_clk_in)
    begin
        if (!rst_n_in)
        begin
            ctr_reg <= '0;
            buf_index_reg <= PSC_ZERO64;
            ovf0_reg <= 1'b0;
            buf_full_reg <= 1'b0;
        end
        else
        begin
            if (stored)
            begin
                ctr_reg <= reload_reg[CTR_WIDTH-1:0];
            end
            else if (wr_ok && hit_ctr)
            begin
                ctr_reg <= msr_wdata_in[CTR_WIDTH-1:0];
            end
            else if (count_on && event_in)
            begin
                ctr_reg <= ctr_reg + 1'b1;
            end
            if (stored)
            begin
                buf_index_reg <= next_index;
            end
            else if (wr_ok && hit_index)
            begin
                buf_index_reg <= msr_wdata_in;
            end
            // a new overflow wins over clearing
            ovf0_reg <= ovf_hit
                || (ovf0_reg && !stored && !ovf_clr_bits[PSC_STS_OVF0_BIT]);
            buf_full_reg <= buf_int_src
                || (buf_full_reg && !ovf_clr_bits[PSC_STS_BUF_FULL_BIT]);
        end
    end

    // interrupt, branch trace ordering and instruction hold
    always_ff @(posedge sys_clk_in)
    begin
        if (!rst_n_in)
        begin
            irq_pend_reg <= 1'b0;
            irq_reg <= 1'b0;
            bts_pend_reg <= 1'b0;
            bts_busy_reg <= 1'b0;
            bts_go_reg <= 1'b0;
            insn_hold_reg <= 1'b0;
        end
        else
        begin
            irq_pend_reg <= ovf_int_src || buf_int_src || (irq_pend_reg && !irq_fire);
            irq_reg <= irq_fire;
            bts_pend_reg <= branch_trace_req_in || (bts_pend_reg && !bts_grant);
            bts_busy_reg <= bts_grant || (bts_busy_reg && !branch_trace_done_in);
            bts_go_reg <= bts_grant;
            insn_hold_reg <= !TRAP_LIKE && ((state_next == PSC_ST_CHECK)
                || (state_next == PSC_ST_WRITE));
        end
    end

    // register read answer
    always_ff @(posedge sys_clk_in)
    begin
        if (!rst_n_in)
        begin
            rdata_reg <= PSC_ZERO64;
            rd_valid_reg <= 1'b0;
            err_reg <= 1'b0;
        end
        else
        begin
            rdata_reg <= rd_ok ? rd_word : PSC_ZERO64;
            rd_valid_reg <= rd_ok;
            err_reg <= (msr_rd_in && !rd_ok) || (msr_wr_in && hit_any && rd_only)
                || (msr_wr_in && !hit_any);
        end
    end

    psc_bounds u_bounds (
        .index_in(buf_index_reg),
        .abs_max_in(buf_max_reg),
        .thresh_in(buf_thresh_reg),
        .words_in(rec_words),
        .fits_out(fits),
        .reach_thresh_out(reach_thresh),
        .next_index_out(next_index)
    );

    psc_record_writer u_writer (
        .sys_clk_in(sys_clk_in),
        .rst_n_in(rst_n_in),
        .start_in(check_pass),
        .base_in(buf_index_reg),
        .words_in(rec_words),
        .fmt_in(RECORD_FMT),
        .status_in(status_word),
        .core_word_in(core_word_in),
        .mem_ready_in(mem_ready_in),
        .mem_valid_out(mem_valid_out),
        .mem_addr_out(mem_addr_out),
        .mem_data_out(mem_data_out),
        .word_sel_out(core_word_sel_out),
        .done_out(writer_done)
    );

    assign msr_rdata_out = rdata_reg;
    assign msr_rd_valid_out = rd_valid_reg;
    assign msr_err_out = err_reg;
    assign insn_hold_out = insn_hold_reg;
    assign branch_trace_go_out = bts_go_reg;
    assign counter_overflow_interrupt_out = irq_reg;
    assign sample_done_out = writer_done;
endmodule
`default_nettype wire

// ### psc_pkg.sv
package psc_pkg;
    localparam logic [11:0] PSC_ADDR_GLB_STATUS = 12'h38e;
    localparam logic [11:0] PSC_ADDR_GLB_ENABLE = 12'h38f;
    localparam logic [11:0] PSC_ADDR_OVF_CLEAR = 12'h390;
    localparam logic [11:0] PSC_ADDR_SAMPLE_EN = 12'h3f1;
    localparam logic [11:0] PSC_ADDR_CAPS = 12'h3e0;
    localparam logic [11:0] PSC_ADDR_MISC = 12'h3e1;
    localparam logic [11:0] PSC_ADDR_EVTSEL = 12'h3e2;
    localparam logic [11:0] PSC_ADDR_COUNTER = 12'h3e3;
    localparam logic [11:0] PSC_ADDR_BUF_INDEX = 12'h3e4;
    localparam logic [11:0] PSC_ADDR_BUF_MAX = 12'h3e5;
    localparam logic [11:0] PSC_ADDR_BUF_THRESH = 12'h3e6;
    localparam logic [11:0] PSC_ADDR_RELOAD = 12'h3e7;
    localparam logic [11:0] PSC_ADDR_CONTENT_SEL = 12'h3e8;
    localparam int PSC_SAMPLE_ON_BIT = 0;
    localparam int PSC_CAP_TRAP_BIT = 6;
    localparam int PSC_CAP_SAVE_ALL_BIT = 7;
    localparam int PSC_CAP_FMT_LSB = 8;
    localparam int PSC_MISC_MON_BIT = 7;
    localparam int PSC_MISC_ABSENT_BIT = 12;
    localparam int PSC_EVT_ENABLE_BIT = 22;
    localparam int PSC_EVT_INT_BIT = 20;
    localparam int PSC_STS_OVF0_BIT = 0;
    localparam int PSC_STS_BUF_FULL_BIT = 62;
    localparam logic [63:0] PSC_WORD_BYTES = 64'h8;
    localparam logic [7:0] PSC_CTR_FIELD_WORD = 8'h12;
    localparam logic [63:0] PSC_CTR_ZERO_MASK = 64'h1;
    localparam logic [63:0] PSC_ZERO64 = 64'h0;
    localparam logic [7:0] PSC_WORDS_BASIC = 8'h12;
    localparam logic [7:0] PSC_WORDS_LATENCY = 8'h16;
    localparam logic [7:0] PSC_WORDS_TUNING = 8'h18;
    localparam logic [7:0] PSC_WORDS_TIMESTAMP = 8'h19;
    localparam logic [7:0] PSC_WORDS_SEL_HEAD = 8'h4;
    localparam logic [7:0] PSC_WORDS_SEL_GPR = 8'h12;
    localparam logic [7:0] PSC_WORDS_SEL_MEM = 8'h4;
    localparam logic [7:0] PSC_WORDS_SEL_LBR = 8'h2;

    typedef enum logic [3:0] {
        PSC_FMT_BASIC = 4'h0,
        PSC_FMT_LATENCY = 4'h1,
        PSC_FMT_TUNING = 4'h2,
        PSC_FMT_TIMESTAMP = 4'h3,
        PSC_FMT_SELECTED = 4'h4
    } psc_fmt_t;

    function automatic logic [7:0] psc_record_words(input logic [3:0] fmt, input logic [2:0] sel);
        logic [7:0] n;
        n = PSC_WORDS_BASIC;
        case (fmt)
            PSC_FMT_LATENCY: n = PSC_WORDS_LATENCY;
            PSC_FMT_TUNING: n = PSC_WORDS_TUNING;
            PSC_FMT_TIMESTAMP: n = PSC_WORDS_TIMESTAMP;
            PSC_FMT_SELECTED:
                n = PSC_WORDS_SEL_HEAD + (sel[0] ? PSC_WORDS_SEL_GPR : 8'h0)
                    + (sel[1] ? PSC_WORDS_SEL_MEM : 8'h0) + (sel[2] ? PSC_WORDS_SEL_LBR : 8'h0);
            default: n = PSC_WORDS_BASIC;
        endcase
        return n;
    endfunction
endpackage

// ### psc_bounds.sv
`timescale 1ns/10ps
`default_nettype none
module psc_bounds
    import psc_pkg::*;
(
    input wire logic [63:0] index_in,
    input wire logic [63:0] abs_max_in,
    input wire logic [63:0] thresh_in,
    input wire logic [7:0] words_in,
    output logic fits_out,
    output logic reach_thresh_out,
    output logic [63:0] next_index_out
);
    wire [63:0] rec_bytes = {56'h0, words_in} * PSC_WORD_BYTES;
    // record must end at or below the absolute maximum
    assign next_index_out = index_in + rec_bytes;
    assign fits_out = (next_index_out <= abs_max_in) && (next_index_out > index_in);
    assign reach_thresh_out = next_index_out >= thresh_in;
endmodule
`default_nettype wire

// ### psc_record_writer.sv
`timescale 1ns/10ps
`default_nettype none
module psc_record_writer
    import psc_pkg::*;
(
    input wire logic sys_clk_in,
    input wire logic rst_n_in,
    input wire logic start_in,
    input wire logic [63:0] base_in,
    input wire logic [7:0] words_in,
    input wire logic [3:0] fmt_in,
    input wire logic [63:0] status_in,
    input wire logic [63:0] core_word_in,
    input wire logic mem_ready_in,
    output logic mem_valid_out,
    output logic [63:0] mem_addr_out,
    output logic [63:0] mem_data_out,
    output logic [7:0] word_sel_out,
    output logic done_out
);
    logic [7:0] left_reg;
    wire [7:0] nxt_sel = word_sel_out + 8'h1;
    wire take = mem_valid_out && mem_ready_in;
    // word_sel_out names the word loaded next, so word 0 is ready when a record starts
    // word at the counter field carries status or the applicable-counter mask
    wire ctr_word = (word_sel_out == PSC_CTR_FIELD_WORD) && (fmt_in != PSC_FMT_BASIC)
        && (fmt_in != PSC_FMT_SELECTED);
    wire [63:0] ctr_data = (fmt_in == PSC_FMT_TIMESTAMP) ? PSC_CTR_ZERO_MASK : status_in;
    always_ff @(posedge sys_clk_in)
    begin
        if (!rst_n_in)
        begin
            mem_valid_out <= 1'b0;
            mem_addr_out <= PSC_ZERO64;
            mem_data_out <= PSC_ZERO64;
            word_sel_out <= 8'h0;
            left_reg <= 8'h0;
            done_out <= 1'b0;
        end
        else if (start_in)
        begin
            mem_valid_out <= 1'b1;
            mem_addr_out <= base_in;
            mem_data_out <= core_word_in;
            word_sel_out <= 8'h1;
            left_reg <= words_in - 8'h1;
            done_out <= 1'b0;
        end
        else if (take)
        begin
            // 64-bit entries, one per word address
            mem_valid_out <= left_reg != 8'h0;
            mem_addr_out <= mem_addr_out + PSC_WORD_BYTES;
            mem_data_out <= ctr_word ? ctr_data : core_word_in;
            // back to word 0 after the last word, ready for the next record
            word_sel_out <= (left_reg == 8'h0) ? 8'h0 : nxt_sel;
            left_reg <= left_reg - 8'h1;
            done_out <= left_reg == 8'h0;
        end
        else
        begin
            done_out <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// ### psc_control_properties.sv
`timescale 1ns/10ps
`default_nettype none
module psc_properties
    import psc_pkg::*;
#(
    parameter int CTR_WIDTH = 48,
    parameter logic TRAP_LIKE = 1'b1,
    parameter logic [3:0] RECORD_FMT = 4'h0
)
(
    input wire logic sys_clk_in,
    input wire logic rst_n_in,
    input wire logic msr_wr_in,
    input wire logic msr_rd_in,
    input wire logic [11:0] msr_addr_in,
    input wire logic mem_ready_in,
    input wire logic [63:0] msr_rdata_out,
    input wire logic msr_rd_valid_out,
    input wire logic msr_err_out,
    input wire logic mem_valid_out,
    input wire logic [63:0] mem_addr_out,
    input wire logic insn_hold_out,
    input wire logic branch_trace_go_out,
    input wire logic counter_overflow_interrupt_out,
    input wire logic sample_done_out
);
    default clocking @(posedge sys_clk_in);
    endclocking
    default disable iff (!rst_n_in);
    clr_read_a:
    assert property (msr_rd_in && msr_addr_in == PSC_ADDR_OVF_CLEAR
        |=> msr_err_out && !msr_rd_valid_out) else $error("clear register read not refused");
    caps_value_a:
    assert property (msr_rd_in && msr_addr_in == PSC_ADDR_CAPS |=> msr_rd_valid_out
        && msr_rdata_out[11:6] == {RECORD_FMT, 1'b1, TRAP_LIKE}) else $error("bad caps");
    misc_value_a:
    assert property (msr_rd_in && msr_addr_in == PSC_ADDR_MISC |=> msr_rd_valid_out
        && msr_rdata_out[7] && !msr_rdata_out[12]) else $error("bad feature bits");
    status_ro_a:
    assert property (msr_wr_in && msr_addr_in == PSC_ADDR_GLB_STATUS |=> msr_err_out)
        else $error("status write not refused");
    word_hold_a:
    assert property (mem_valid_out && !mem_ready_in |=> mem_valid_out && $stable(mem_addr_out))
        else $error("record word dropped");
    addr_step_a:
    assert property (mem_valid_out && mem_ready_in ##1 mem_valid_out
        |-> mem_addr_out == $past(mem_addr_out) + PSC_WORD_BYTES) else $error("bad step");
    trace_after_a:
    assert property (branch_trace_go_out |-> !mem_valid_out) else $error("trace during record");
    irq_order_a:
    assert property (counter_overflow_interrupt_out |-> !mem_valid_out && !branch_trace_go_out)
        else $error("interrupt not held");
    hold_mode_a:
    assert property (mem_valid_out |-> insn_hold_out == !TRAP_LIKE) else $error("bad hold");
    cover property (sample_done_out);
    cover property (counter_overflow_interrupt_out);
    cover property (branch_trace_go_out);
endmodule
bind psc_control psc_properties #(.CTR_WIDTH(CTR_WIDTH), .TRAP_LIKE(TRAP_LIKE),
    .RECORD_FMT(RECORD_FMT)) u_props (.sys_clk_in, .rst_n_in, .msr_wr_in, .msr_rd_in,
    .msr_addr_in, .mem_ready_in, .msr_rdata_out, .msr_rd_valid_out, .msr_err_out,
    .mem_valid_out, .mem_addr_out, .insn_hold_out, .branch_trace_go_out,
    .counter_overflow_interrupt_out, .sample_done_out);
`default_nettype wire

// ### tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb;
    import psc_pkg::*;
    localparam logic [63:0] ONES = 64'hffff_ffff_ffff;
    localparam logic [63:0] B62 = 64'h4000_0000_0000_0000;
    logic sys_clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic msr_wr_in = 1'b0;
    logic msr_rd_in = 1'b0;
    logic [11:0] msr_addr_in = 12'h0;
    logic [63:0] msr_wdata_in = 64'h0;
    logic event_in = 1'b0;
    logic insn_complete_in = 1'b0;
    logic freeze_on_overflow_irq_in = 1'b0;
    logic branch_trace_req_in = 1'b0;
    logic branch_trace_done_in = 1'b0;
    logic mem_ready_in = 1'b0;
    logic [63:0] msr_rdata_out, mem_addr_out, mem_data_out, got, m_idx, r;
    logic [63:0] exp_q[$];
    logic msr_rd_valid_out, msr_err_out, mem_valid_out, insn_hold_out, branch_trace_go_out;
    logic counter_overflow_interrupt_out, sample_done_out, gerr, gval;
    logic [7:0] core_word_sel_out;
    wire logic [63:0] core_word_in = {32'hc0de0000, 24'h0, core_word_sel_out};
    int bad_count = 0;
    int total_checks = 0;
    int nw = 0;
    int irqs = 0;
    int gos = 0;
    int dones = 0;
    psc_control u_dut (
        .sys_clk_in, .rst_n_in, .msr_wr_in, .msr_rd_in, .msr_addr_in, .msr_wdata_in, .event_in,
        .insn_complete_in, .core_word_in, .freeze_on_overflow_irq_in, .branch_trace_req_in,
        .branch_trace_done_in, .mem_ready_in, .msr_rdata_out, .msr_rd_valid_out, .msr_err_out,
        .mem_valid_out, .mem_addr_out, .mem_data_out, .core_word_sel_out, .insn_hold_out,
        .branch_trace_go_out, .counter_overflow_interrupt_out, .sample_done_out
    );
    initial
        forever #2.5 sys_clk_in = ~sys_clk_in;
    task automatic check(input logic [63:0] g, input logic [63:0] e);
        total_checks++;
        if (g !== e)
        begin
            bad_count++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic wrap_up;
        if (bad_count == 0 && total_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic acc(input logic w, input logic [11:0] a, input logic [63:0] d);
        @(negedge sys_clk_in);
        msr_wr_in = w;
        msr_rd_in = !w;
        msr_addr_in = a;
        msr_wdata_in = d;
        @(negedge sys_clk_in);
        msr_wr_in = 1'b0;
        msr_rd_in = 1'b0;
        got = msr_rdata_out;
        gerr = msr_err_out;
        gval = msr_rd_valid_out;
    endtask
    task automatic rdc(input logic [11:0] a, input logic [63:0] e, input logic [63:0] m);
        acc(1'b0, a, 64'h0);
        check(gval, 64'h1);
        check(got & m, e);
    endtask
    task automatic refuse(input logic w, input logic [11:0] a);
        acc(w, a, ONES);
        check(gerr, 64'h1);
    endtask
    task automatic pulse_ev(input logic bt);
        @(negedge sys_clk_in);
        event_in = 1'b1;
        branch_trace_req_in = bt;
        @(negedge sys_clk_in);
        event_in = 1'b0;
        branch_trace_req_in = 1'b0;
    endtask
    task automatic sample(input int n, input int ie);
        int i0;
        int g0;
        int d0;
        i0 = irqs;
        g0 = gos;
        d0 = dones;
        nw = 0;
        for (int k = 0; k < n; k++)
            exp_q.push_back(m_idx + 64'(8 * k));
        acc(1'b1, PSC_ADDR_GLB_ENABLE, 64'h0);
        acc(1'b1, PSC_ADDR_COUNTER, ONES);
        acc(1'b1, PSC_ADDR_GLB_ENABLE, 64'h1);
        pulse_ev(1'b0);
        pulse_ev(1'b1);
        insn_complete_in = 1'b1;
        @(negedge sys_clk_in);
        insn_complete_in = 1'b0;
        for (int i = 0; i < 200 && gos == g0; i++)
            @(negedge sys_clk_in);
        repeat (4) @(negedge sys_clk_in);
        check(irqs, i0);
        branch_trace_done_in = 1'b1;
        @(negedge sys_clk_in);
        branch_trace_done_in = 1'b0;
        repeat (6) @(negedge sys_clk_in);
        check(gos, g0 + 1);
        check(nw, n);
        check(dones, d0 + int'(n != 0));
        check(exp_q.size(), 64'h0);
        check(irqs, i0 + ie);
        m_idx += 64'(8 * n);
        rdc(PSC_ADDR_BUF_INDEX, m_idx, '1);
    endtask
    always @(negedge sys_clk_in)
        mem_ready_in <= 1'($urandom % 2);
    always @(posedge sys_clk_in)
    begin
        irqs += int'(counter_overflow_interrupt_out === 1'b1);
        gos += int'(branch_trace_go_out === 1'b1);
        dones += int'(sample_done_out === 1'b1);
        if (mem_valid_out === 1'b1 && mem_ready_in)
        begin
            check(exp_q.size() != 0, 64'h1);
            if (exp_q.size() != 0)
                check(mem_addr_out, exp_q.pop_front());
            check(mem_data_out, {32'hc0de0000, 24'h0, 8'(nw)});
            check(insn_hold_out, 64'h0);
            nw++;
        end
    end
    initial
    begin
        #100us;
        bad_count++;
        wrap_up();
    end
    initial
    begin
        void'($urandom(32'h4dcadbde));
        repeat (6) @(negedge sys_clk_in);
        rst_n_in = 1'b1;
        rdc(PSC_ADDR_GLB_STATUS, 64'h0, '1);
        rdc(PSC_ADDR_CAPS, 64'h0c0, 64'hfc0);
        rdc(PSC_ADDR_MISC, 64'h080, 64'h1080);
        refuse(1'b0, PSC_ADDR_OVF_CLEAR);
        refuse(1'b1, PSC_ADDR_GLB_STATUS);
        refuse(1'b0, 12'h000);
        rdc(PSC_ADDR_GLB_STATUS, 64'h0, '1);
        for (int i = 0; i < 3; i++)
        begin
            r = {$urandom, $urandom};
            acc(1'b1, PSC_ADDR_BUF_INDEX + 12'(i), r);
            rdc(PSC_ADDR_BUF_INDEX + 12'(i), r, '1);
        end
        acc(1'b1, PSC_ADDR_SAMPLE_EN, r);
        rdc(PSC_ADDR_SAMPLE_EN, r & 64'h1, 64'h1);
        acc(1'b1, PSC_ADDR_GLB_ENABLE, 64'h0);
        acc(1'b1, PSC_ADDR_SAMPLE_EN, 64'h0);
        m_idx = 64'h1000;
        acc(1'b1, PSC_ADDR_BUF_INDEX, m_idx);
        acc(1'b1, PSC_ADDR_BUF_MAX, 64'h10000);
        acc(1'b1, PSC_ADDR_BUF_THRESH, 64'hffff0);
        acc(1'b1, PSC_ADDR_RELOAD, ONES);
        acc(1'b1, PSC_ADDR_EVTSEL, 64'h40_0000);
        sample(0, 0);
        rdc(PSC_ADDR_GLB_STATUS, 64'h1, '1);
        acc(1'b1, PSC_ADDR_OVF_CLEAR, 64'h1);
        acc(1'b1, PSC_ADDR_SAMPLE_EN, 64'h1);
        sample(int'(PSC_WORDS_BASIC), 0);
        rdc(PSC_ADDR_GLB_STATUS, 64'h0, '1);
        rdc(PSC_ADDR_COUNTER, ONES, '1);
        acc(1'b1, PSC_ADDR_BUF_THRESH, m_idx + 64'(8 * PSC_WORDS_BASIC));
        freeze_on_overflow_irq_in = 1'b1;
        sample(int'(PSC_WORDS_BASIC), 1);
        freeze_on_overflow_irq_in = 1'b0;
        rdc(PSC_ADDR_GLB_ENABLE, 64'h0, 64'h1);
        rdc(PSC_ADDR_GLB_STATUS, B62, '1);
        acc(1'b1, PSC_ADDR_OVF_CLEAR, B62 | 64'h1);
        rdc(PSC_ADDR_GLB_STATUS, 64'h0, '1);
        acc(1'b1, PSC_ADDR_BUF_MAX, m_idx + 64'h10);
        sample(0, 1);
        rdc(PSC_ADDR_GLB_STATUS, B62, B62);
        wrap_up();
    end
endmodule
`default_nettype wire
